// >>> ssf_pkg.sv
// Package for the serial status flag block: register map, field positions, reset values.
// Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
package ssf_pkg;

  // ====================================================================
  // Register byte addresses
  localparam logic [7:0] SSF_ADDR_STATUS  = 8'h00;
  localparam logic [7:0] SSF_ADDR_CONTROL = 8'h04;
  localparam logic [7:0] SSF_ADDR_TXDATA  = 8'h08;
  localparam logic [7:0] SSF_ADDR_RXDATA  = 8'h0c;
  localparam logic [7:0] SSF_ADDR_MASK    = 8'h10;
  localparam logic [7:0] SSF_ADDR_IRQSTAT = 8'h14;

  // ====================================================================
  // Status and control register fields
  localparam int SSF_BIT_TX_EMPTY = 7;
  localparam int SSF_BIT_RX_FULL  = 6;
  localparam int SSF_BIT_OVERRUN  = 5;
  localparam int SSF_BIT_FRAMING  = 4;
  localparam int SSF_BIT_TX_EN    = 5;

  // ====================================================================
  // Reset values
  localparam logic [3:0] SSF_FLAGS_RESET = 4'h8;
  localparam logic [3:0] SSF_MASK_RESET  = 4'h0;

  // ====================================================================
  // Bus encodings
  localparam logic [1:0] SSF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SSF_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] SSF_HSIZE_WORD    = 3'h2;
  localparam logic [1:0] SSF_HRESP_OKAY    = 2'h0;

  // Order of the four flags inside the flag vector
  typedef enum logic [1:0]
  {
    SSF_F_FER  = 2'b00,
    SSF_F_OER  = 2'b01,
    SSF_F_RX_BUFFER_FULL_FLAG = 2'b10,
    SSF_F_TX_BUFFER_EMPTY_FLAG = 2'b11
  } ssf_flag_idx_type;

endpackage

// >>> ssf_flag.sv
// One status flag with hardware set, read-then-write-0 clear and auto clear.
// Assumes one clock domain; strobes are single-cycle pulses on ref_clk_i, except set_i, which may be held high as a level.
module ssf_flag
  import ssf_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Events
  input  wire logic set_i,
  input  wire logic hw_clear_i,
  input  wire logic read_i,
  input  wire logic write_i,
  input  wire logic wdata_bit_i,
  // State
  output logic      flag_o
);

  logic flag_q;
  logic armed_q;
  logic sw_clear;

  // A zero write clears only after a read saw the flag as one
  assign sw_clear = write_i && !wdata_bit_i && armed_q;

  // ====================================================================
  // Flag
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flag_q <= RESET_VAL;
    else if (set_i)
      flag_q <= 1'b1;
    else if (sw_clear || hw_clear_i)
      flag_q <= 1'b0;
  end

  // ====================================================================
  // Read-as-one arm; a fresh set disarms so a reset flag needs a new read
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      armed_q <= 1'b0;
    else if (set_i || write_i)
      armed_q <= 1'b0;
    else if (read_i)
      armed_q <= flag_q;
  end

  assign flag_o = flag_q;

endmodule // ssf_flag

// >>> ssf_serial_status.sv
// Serial status flags with AHB-Lite register access and a masked interrupt.
// Assumes the shift paths deliver single-cycle strobes on ref_clk_i.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
module ssf_serial_status
  import ssf_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic      [1:0]  hresp_o,
  // Shift path side
  input  wire logic        tx_load_i,
  input  wire logic        rx_done_i,
  input  wire logic        rx_overrun_i,
  input  wire logic        rx_framing_i,
  input  wire logic [7:0]  rx_data_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_data_wr_o,
  output logic             transmit_enable_o,
  // Interrupt
  output logic             irq_o
);

  // ====================================================================
  // Bus address phase capture
  logic       acc_q;
  logic       wr_q;
  logic [7:0] addr_q;
  logic       rd_phase;
  logic       wr_phase;
  logic       valid_xfer;

  assign valid_xfer = hsel_i && hready_i && (htrans_i == SSF_HTRANS_NONSEQ || htrans_i == SSF_HTRANS_SEQ);

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (hready_i)
    begin
      acc_q  <= valid_xfer;
      wr_q   <= hwrite_i;
      addr_q <= haddr_i[7:0];
    end
  end

  // Every access completes in one data-phase cycle with no wait state
  assign hreadyout_o = 1'b1;
  assign hresp_o     = SSF_HRESP_OKAY;
  assign rd_phase    = acc_q && !wr_q;
  assign wr_phase    = acc_q && wr_q;

  // ====================================================================
  // Decoded strobes
  logic st_rd;
  logic st_wr;
  logic ctl_wr;
  logic txd_wr;
  logic rxd_rd;
  logic msk_wr;
  logic irq_rd;

  assign st_rd  = rd_phase && addr_q == SSF_ADDR_STATUS;
  assign st_wr  = wr_phase && addr_q == SSF_ADDR_STATUS;
  assign ctl_wr = wr_phase && addr_q == SSF_ADDR_CONTROL;
  assign txd_wr = wr_phase && addr_q == SSF_ADDR_TXDATA;
  assign rxd_rd = rd_phase && addr_q == SSF_ADDR_RXDATA;
  assign msk_wr = wr_phase && addr_q == SSF_ADDR_MASK;
  assign irq_rd = rd_phase && addr_q == SSF_ADDR_IRQSTAT;

  // ====================================================================
  // Control, data and mask registers
  logic       tx_en_q;
  logic [7:0] tx_data_q;
  logic       tx_data_wr_q;
  logic [7:0] rx_data_q;
  logic [3:0] mask_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      tx_en_q <= 1'b0;
    else if (ctl_wr)
      tx_en_q <= hwdata_i[SSF_BIT_TX_EN];
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_data_q    <= 8'h00;
      tx_data_wr_q <= 1'b0;
    end
    else
    begin
      tx_data_wr_q <= txd_wr;
      if (txd_wr)
        tx_data_q <= hwdata_i[7:0];
    end
  end

  // Only a clean reception updates the holding register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rx_data_q <= 8'h00;
    else if (rx_done_i && !rx_framing_i && !rx_overrun_i)
      rx_data_q <= rx_data_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      mask_q <= SSF_MASK_RESET;
    else if (msk_wr)
      mask_q <= hwdata_i[SSF_BIT_TX_EMPTY:SSF_BIT_FRAMING];
  end

  // ====================================================================
  // Flags
  logic [3:0] set_ev;
  logic [3:0] hw_clr;
  logic [3:0] flags;
  logic [3:0] wbits;

  assign set_ev[SSF_F_TX_BUFFER_EMPTY_FLAG] = tx_load_i || !tx_en_q;
  assign set_ev[SSF_F_RX_BUFFER_FULL_FLAG] = rx_done_i && !rx_framing_i && !rx_overrun_i;
  assign set_ev[SSF_F_OER]  = rx_overrun_i;
  assign set_ev[SSF_F_FER]  = rx_framing_i;

  assign hw_clr[SSF_F_TX_BUFFER_EMPTY_FLAG] = txd_wr;
  assign hw_clr[SSF_F_RX_BUFFER_FULL_FLAG] = rxd_rd;
  assign hw_clr[SSF_F_OER]  = 1'b0;
  assign hw_clr[SSF_F_FER]  = 1'b0;

  // Writing 1 never sets: the flag cell only accepts a 0 as a clear
  assign wbits = hwdata_i[SSF_BIT_TX_EMPTY:SSF_BIT_FRAMING];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flag
      ssf_flag #(
        .RESET_VAL (SSF_FLAGS_RESET[gi])
      ) u_flag (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .set_i       (set_ev[gi]),
        .hw_clear_i  (hw_clr[gi]),
        .read_i      (st_rd),
        .write_i     (st_wr),
        .wdata_bit_i (wbits[gi]),
        .flag_o      (flags[gi])
      );
    end
  endgenerate

  // ====================================================================
  // Interrupt status: sticky on flag rising, cleared by read, set wins
  logic [3:0] flags_prev_q;
  logic [3:0] irq_stat_q;
  logic [3:0] rise;

  assign rise = flags & ~flags_prev_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_prev_q <= SSF_FLAGS_RESET;
    else
      flags_prev_q <= flags;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_stat_q <= 4'h0;
    else if (irq_rd)
      irq_stat_q <= rise;
    else
      irq_stat_q <= irq_stat_q | rise;
  end

  assign irq_o = |(irq_stat_q & mask_q);

  // ====================================================================
  // Read data: registered so it stands for the data phase
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (haddr_i[7:0])
      SSF_ADDR_STATUS:  rdata_d[SSF_BIT_TX_EMPTY:SSF_BIT_FRAMING] = flags;
      SSF_ADDR_CONTROL: rdata_d[SSF_BIT_TX_EN] = tx_en_q;
      SSF_ADDR_TXDATA:  rdata_d[7:0] = tx_data_q;
      SSF_ADDR_RXDATA:  rdata_d[7:0] = rx_data_q;
      SSF_ADDR_MASK:    rdata_d[SSF_BIT_TX_EMPTY:SSF_BIT_FRAMING] = mask_q;
      SSF_ADDR_IRQSTAT: rdata_d[SSF_BIT_TX_EMPTY:SSF_BIT_FRAMING] = irq_stat_q;
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  // Status is sampled at the address phase; a flag change in between shows next read
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else if (valid_xfer && !hwrite_i)
      rdata_q <= rdata_d;
  end

  assign hrdata_o          = rdata_q;
  assign tx_data_o         = tx_data_q;
  assign tx_data_wr_o      = tx_data_wr_q;
  assign transmit_enable_o = tx_en_q;

endmodule // ssf_serial_status

// >>> ssf_serial_status_sva.sv
// Checker for the serial status flags: bus answers, data paths, control.
// Sees only top ports; bound to every ssf_serial_status instance.
module ssf_serial_status_sva
  import ssf_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic [1:0]  hresp_o,
  input wire logic        rx_done_i,
  input wire logic        rx_overrun_i,
  input wire logic        rx_framing_i,
  input wire logic [7:0]  rx_data_i,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_data_wr_o,
  input wire logic        transmit_enable_o,
  input wire logic        irq_o
);
  // ====================
  // Data phase tracking
  logic       r_q;
  logic       w_q;
  logic [7:0] a_q;
  logic [7:0] rx_q;
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      r_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= 8'h00;
    end
    else
    begin
      r_q <= hsel_i && hready_i && htrans_i[1] && !hwrite_i;
      w_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      a_q <= haddr_i[7:0];
    end
  // Only clean receptions reach the holding register
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      rx_q <= 8'h00;
    else if (rx_done_i && !rx_overrun_i && !rx_framing_i)
      rx_q <= rx_data_i;
  wire rd_st = r_q && a_q == SSF_ADDR_STATUS;
  wire rd_rx = r_q && a_q == SSF_ADDR_RXDATA;
  wire wtx   = w_q && a_q == SSF_ADDR_TXDATA;
  wire wct   = w_q && a_q == SSF_ADDR_CONTROL;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // Properties
  property p_bus; hreadyout_o && hresp_o == SSF_HRESP_OKAY; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
  property p_te; rd_st && !transmit_enable_o && !$past(transmit_enable_o) |-> hrdata_o[7]; endproperty
  a_te: assert property (p_te) else $error("tx empty low while disabled");
  property p_txd; wtx |=> tx_data_wr_o && tx_data_o == $past(hwdata_i[7:0]); endproperty
  a_txd: assert property (p_txd) else $error("tx data not passed on");
  property p_wrc; tx_data_wr_o |-> $past(wtx); endproperty
  a_wrc: assert property (p_wrc) else $error("spurious tx data strobe");
  property p_rxd; rd_rx |-> hrdata_o[7:0] == rx_q; endproperty
  a_rxd: assert property (p_rxd) else $error("rx holding data wrong");
  property p_unm; r_q && a_q > SSF_ADDR_IRQSTAT |-> hrdata_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_ctl; wct |=> transmit_enable_o == $past(hwdata_i[SSF_BIT_TX_EN]); endproperty
  a_ctl: assert property (p_ctl) else $error("transmit enable not written");
  property p_hold; !r_q |-> $stable(hrdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  c_tx: cover property (wtx);
  c_rx: cover property (rd_rx);
  c_irq: cover property (irq_o);
endmodule // ssf_serial_status_sva

bind ssf_serial_status ssf_serial_status_sva u_sva (.ref_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .rx_done_i, .rx_overrun_i,
  .rx_framing_i, .rx_data_i, .tx_data_o, .tx_data_wr_o, .transmit_enable_o, .irq_o);

// >>> ssf_shift_model.sv
// Model of the shift paths facing the remote serial partner.
// Assumes one clock; strobes change just after a rising edge.
module ssf_shift_model
#(
  parameter int LOAD_DLY = 12
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic wr_i,
  output logic      load_o,
  output logic      done_o,
  output logic      ovr_o,
  output logic      fer_o,
  output logic [7:0] data_o
);
  int cnt;
  initial {done_o, ovr_o, fer_o, data_o} = 11'h0;
  // Shifter takes the holding data some cycles after a write
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt <= 0;
      load_o <= 1'b0;
    end
    else
    begin
      load_o <= cnt == 1;
      cnt <= wr_i ? LOAD_DLY : (cnt > 0 ? cnt - 1 : 0);
    end
  // Data is inverted once stale so a held value never looks fresh
  task automatic rx(input logic d, o, f, input logic [7:0] b);
    @(posedge clk_i);
    {done_o, ovr_o, fer_o, data_o} <= {d, o, f, b};
    @(posedge clk_i);
    {done_o, ovr_o, fer_o, data_o} <= {3'h0, ~b};
  endtask
endmodule // ssf_shift_model

// >>> ssf_serial_status_tb_top.sv
// Bench for the serial status flags: bus tasks and one task per scenario.
// Assumes the shift model loads transmit data 12 cycles after a write.
module ssf_serial_status_tb_top;
  import ssf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hrdy, load, done, ovr, framing_error_flag, txwr, te, irq;
  logic [1:0]  htrans, hresp;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [7:0]  rxd, txd;
  int          mismatches, checked;
  ssf_serial_status dut (.ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(SSF_HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .tx_load_i(load), .rx_done_i(done), .rx_overrun_i(ovr),
    .rx_framing_i(framing_error_flag), .rx_data_i(rxd), .tx_data_o(txd), .tx_data_wr_o(txwr), .transmit_enable_o(te),
    .irq_o(irq));
  ssf_shift_model #(.LOAD_DLY(12)) peer (.clk_i(clk), .rst_i(rst), .wr_i(txwr), .load_o(load),
    .done_o(done), .ovr_o(ovr), .fer_o(framing_error_flag), .data_o(rxd));
  // ====================
  // Bus and check tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, SSF_HTRANS_NONSEQ, 24'h0, a, w};
    do @(posedge clk); while (hrdy !== 1'b1);
    {hsel, htrans, hwdata} <= {3'h0, wd};
    do @(posedge clk); while (hrdy !== 1'b1);
    x = hrdata;
  endtask
  task automatic see(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic st(input logic [3:0] e);
    bus(0, SSF_ADDR_STATUS, 0);
    see(x[7:4], e, "status flags");
  endtask
  // ====================
  // Scenarios
  task automatic t_tx;
    bus(1, SSF_ADDR_CONTROL, 32'h20);
    bus(1, SSF_ADDR_TXDATA, 32'h5a);
    st(4'h0);
    repeat (20) @(posedge clk);
    st(4'h8);
    bus(1, SSF_ADDR_STATUS, 0);
    st(4'h0);
    bus(1, SSF_ADDR_TXDATA, 32'ha5);
    repeat (20) @(posedge clk);
    bus(1, SSF_ADDR_STATUS, 0);
    st(4'h8);
    bus(1, SSF_ADDR_TXDATA, 32'h3c);
    bus(1, SSF_ADDR_CONTROL, 0);
    st(4'h8);
  endtask
  task automatic t_rx;
    peer.rx(1, 0, 0, 8'ha5);
    st(4'hc);
    bus(0, SSF_ADDR_RXDATA, 0);
    see(x[7:0], 8'ha5, "rx data");
    st(4'h8);
    peer.rx(1, 0, 0, 8'h3c);
    st(4'hc);
    bus(1, SSF_ADDR_STATUS, 0);
    st(4'h8);
  endtask
  task automatic t_err;
    peer.rx(1, 1, 1, 8'hff);
    st(4'hb);
    #1 see(irq, 0, "masked irq");
    bus(1, SSF_ADDR_STATUS, 32'hf0);
    st(4'hb);
    bus(0, SSF_ADDR_RXDATA, 0);
    st(4'hb);
    bus(1, SSF_ADDR_STATUS, 32'hf0);
    bus(1, SSF_ADDR_STATUS, 0);
    st(4'hb);
    peer.rx(0, 0, 1, 8'h00);
    bus(1, SSF_ADDR_STATUS, 0);
    st(4'h9);
    bus(1, SSF_ADDR_STATUS, 0);
    st(4'h8);
  endtask
  task automatic t_irq;
    bus(1, SSF_ADDR_MASK, 32'h10);
    #1 see(irq, 1, "irq not raised");
    bus(0, SSF_ADDR_IRQSTAT, 0);
    #1 see(irq, 0, "irq not cleared");
    bus(0, 8'h1c, 0);
    see(x, 0, "unmapped read");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====================
  // Clock, watchdog, main sequence
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    // Reset is raised at time zero so every flop starts from its reset value
    rst        = 1'b1;
    hsel       = 1'b0;
    htrans     = 2'h0;
    haddr      = 32'h0000_0000;
    hwrite     = 1'b0;
    hwdata     = 32'h0000_0000;
    mismatches = 0;
    checked    = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    st(4'h8);
    t_tx;
    t_rx;
    t_err;
    t_irq;
    tally_and_finish;
  end
endmodule // ssf_serial_status_tb_top
